//--- sync_trigger_pkg.sv
package sync_trigger_pkg;

   // ****************************************
   // Sizes
   // ****************************************
   localparam int NUM_AXES = 4;
   localparam int POS_W    = 32;
   localparam int DATA_W   = 16;
   localparam int ADDR_W   = 4;

   // ****************************************
   // Register offsets (word index on the host port)
   // ****************************************
   localparam logic [ADDR_W-1:0] ADDR_COMMAND      = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_DATA_LOW     = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_DATA_HIGH    = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_MODE_TWO     = 4'h3;
   localparam logic [ADDR_W-1:0] ADDR_STATUS_THREE = 4'h4;  // 4..7, one per axis
   localparam logic [ADDR_W-1:0] ADDR_SYNC_BUF     = 4'h8;  // 8..15, low/high per axis

   // ****************************************
   // Command register layout and codes
   // ****************************************
   localparam int         CMD_AXIS_LSB      = 8;
   localparam logic [7:0] CMD_SYNC_MODE_SET = 8'h64;
   localparam logic [7:0] CMD_SYNC_START    = 8'h65;
   localparam logic [7:0] CMD_LP_READ       = 8'h10;

   // ****************************************
   // Trigger word bit positions
   // ****************************************
   localparam int TRIG_UP_GE     = 0;
   localparam int TRIG_UP_LT     = 1;
   localparam int TRIG_LO_LT     = 2;
   localparam int TRIG_LO_GE     = 3;
   localparam int TRIG_DRV_BEGIN = 4;
   localparam int TRIG_DRV_END   = 5;
   localparam int TRIG_GIN_RISE  = 6;
   localparam int TRIG_GIN_FALL  = 7;
   localparam int TRIG_POS_READ  = 8;
   localparam int TRIG_START_CMD = 9;
   localparam int TRIG_NUM       = 10;
   localparam int TRIG_OTHER_LSB = 13;

   // ****************************************
   // Action word bit positions
   // ****************************************
   localparam int ACT_FIXED_FWD   = 0;
   localparam int ACT_FIXED_REV   = 1;
   localparam int ACT_CONT_FWD    = 2;
   localparam int ACT_CONT_REV    = 3;
   localparam int ACT_DEC_HALT    = 4;
   localparam int ACT_INST_HALT   = 5;
   localparam int ACT_LP_CAPTURE  = 6;
   localparam int ACT_EP_CAPTURE  = 7;
   localparam int ACT_LP_LOAD     = 8;
   localparam int ACT_EP_LOAD     = 9;
   localparam int ACT_PCNT_LOAD   = 10;
   localparam int ACT_SPEED_LOAD  = 11;
   localparam int ACT_INTERRUPT   = 15;

   // ****************************************
   // Other fields, reset values, timing
   // ****************************************
   localparam int                MODE_TWO_CMP_SEL   = 5;
   localparam int                STATUS_THREE_SYNC  = 9;
   localparam logic [DATA_W-1:0] TRIG_CFG_RESET     = 16'h0000;
   localparam logic [DATA_W-1:0] ACT_CFG_RESET      = 16'h0000;
   localparam int                SYS_CLK_PERIOD_NS  = 8;
   localparam int                TRIG_TO_ACT_CYCLES = 2;

endpackage : sync_trigger_pkg

//--- sync_trigger_eval.sv
`timescale 1ns/1ps
module sync_trigger_eval
   import sync_trigger_pkg::*;
(
   input  wire logic                      i_sys_clk,     // System clock
   input  wire logic                      i_rst_n,       // Async reset, low
   input  wire logic [sync_trigger_pkg::DATA_W-1:0] i_trig_cfg, // Trigger word
   input  wire logic                      i_cmp_sel,     // 1: actual counter
   input  wire logic [sync_trigger_pkg::POS_W-1:0]  i_lp,       // Logical position
   input  wire logic [sync_trigger_pkg::POS_W-1:0]  i_ep,       // Actual position
   input  wire logic [sync_trigger_pkg::POS_W-1:0]  i_cmp_up,   // Upper compare
   input  wire logic [sync_trigger_pkg::POS_W-1:0]  i_cmp_lo,   // Lower compare
   input  wire logic                      i_drv_begin,   // Drive start pulse
   input  wire logic                      i_drv_end,     // Drive end pulse
   input  wire logic                      i_gin3,        // General input three
   input  wire logic                      i_pos_read,    // Position read command
   input  wire logic                      i_start_cmd,   // Sync start command
   output logic                           o_fire         // Trigger occurred
);
   import sync_trigger_pkg::*;

   typedef struct packed {
      logic [3:0] cmp_prev;
      logic       gin_prev;
      logic       fire;
   } eval_state_t;

   eval_state_t st;
   eval_state_t next_st;

   // ****************************************
   // Event detection
   // ****************************************
   // Compare results fire on the edge into truth, so a held condition fires once
   always_comb begin
      logic signed [POS_W-1:0] pos;
      logic [3:0]              cmp;
      logic [TRIG_NUM-1:0]     ev;
      pos     = i_cmp_sel ? $signed(i_ep) : $signed(i_lp);
      cmp     = '0;
      ev      = '0;
      next_st = st;
      cmp[TRIG_UP_GE] = pos >= $signed(i_cmp_up);
      cmp[TRIG_UP_LT] = pos <  $signed(i_cmp_up);
      cmp[TRIG_LO_LT] = pos <  $signed(i_cmp_lo);
      cmp[TRIG_LO_GE] = pos >= $signed(i_cmp_lo);
      ev[3:0]             = cmp & ~st.cmp_prev;
      ev[TRIG_DRV_BEGIN]  = i_drv_begin;
      ev[TRIG_DRV_END]    = i_drv_end;
      ev[TRIG_GIN_RISE]   = i_gin3 & ~st.gin_prev;
      ev[TRIG_GIN_FALL]   = ~i_gin3 & st.gin_prev;
      ev[TRIG_POS_READ]   = i_pos_read;
      ev[TRIG_START_CMD]  = i_start_cmd;
      next_st.cmp_prev = cmp;
      next_st.gin_prev = i_gin3;
      next_st.fire     = |(ev & i_trig_cfg[TRIG_NUM-1:0]);
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_fire = st.fire;

   a_gin_rise_fire : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_trig_cfg[TRIG_GIN_RISE] && i_gin3 && !st.gin_prev) |=> o_fire)
      else $error("rising input three did not fire");
   a_disabled_quiet : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_trig_cfg[TRIG_NUM-1:0] == '0) |=> !o_fire)
      else $error("fire with every trigger disabled");

endmodule : sync_trigger_eval

//--- sync_action_exec.sv
`timescale 1ns/1ps
module sync_action_exec
   import sync_trigger_pkg::*;
(
   input  wire logic                      i_sys_clk,   // System clock
   input  wire logic                      i_rst_n,     // Async reset, low
   input  wire logic                      i_go,        // Run configured action
   input  wire logic [sync_trigger_pkg::DATA_W-1:0]  i_act_cfg,  // Action word
   input  wire logic [2*sync_trigger_pkg::DATA_W-1:0] i_data,    // Data high:low
   output logic [sync_trigger_pkg::DATA_W-1:0]       o_pulse,   // Action pulses
   output logic [2*sync_trigger_pkg::DATA_W-1:0]     o_load     // Load value
);
   import sync_trigger_pkg::*;

   typedef struct packed {
      logic [DATA_W-1:0]   pulse;
      logic [2*DATA_W-1:0] load;
   } exec_state_t;

   exec_state_t st;
   exec_state_t next_st;

   // ****************************************
   // Action issue
   // ****************************************
   // Load value is frozen at the trigger so later data writes cannot tear it
   always_comb begin
      next_st       = st;
      next_st.pulse = i_go ? i_act_cfg : '0;
      if (i_go) begin
         next_st.load = i_data;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_pulse = st.pulse;
   assign o_load  = st.load;

   a_go_issues_action : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      i_go |=> (o_pulse == $past(i_act_cfg)) && (o_load == $past(i_data)))
      else $error("action not issued one cycle after trigger");
   a_idle_no_action : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      !i_go |=> (o_pulse == '0) && $stable(o_load))
      else $error("action issued without trigger");

endmodule : sync_action_exec

//--- multi_axis_sync_trigger.sv
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
// Behaviour
// - Each trigger and other-axis start bit: 1 enables, 0 disables.
// - Ten trigger sources and thirteen actions per axis.
// - Trigger bit 0 fires when position is at or above upper compare.
// - Mode two compare select picks logical or actual counter.
// - Trigger bit 1 fires when position is below upper compare.
// - Trigger bit 2 fires when position is below lower compare.
// - Trigger bit 3 fires when position is at or above lower compare.
// - Trigger bit 6 fires on rising general input three.
// - Trigger bit 7 fires on falling general input three.
// - Trigger bit 8 fires on the logical position read command 10h.
// - Trigger bit 9 fires on the sync start command 65h.
// - Top three trigger bits start the other three axes' actions.
// - Configured action runs in hardware directly on a trigger.
// - Action bits select drives, halts, captures and loads.
// - Interrupt action pulls output low, sets sync flag; status read clears.
// - Reset disables all triggers and actions on every axis.
// - Compare trigger to first pulse of started axis is two clocks.
module multi_axis_sync_trigger
   import sync_trigger_pkg::*;
#(
   parameter int N_AX = sync_trigger_pkg::NUM_AXES  // Axis count
)(
   input  wire logic                    i_sys_clk,        // System clock
   input  wire logic                    i_rst_n,          // Async reset, low
   input  wire logic [sync_trigger_pkg::ADDR_W-1:0] i_addr,  // Register index
   input  wire logic [sync_trigger_pkg::DATA_W-1:0] i_wdata, // Write data
   input  wire logic                    i_wr,             // Write strobe
   input  wire logic                    i_rd,             // Read strobe
   output logic [sync_trigger_pkg::DATA_W-1:0]      o_rdata, // Read data
   input  wire logic [N_AX*sync_trigger_pkg::POS_W-1:0] i_lp,     // Logical pos
   input  wire logic [N_AX*sync_trigger_pkg::POS_W-1:0] i_ep,     // Actual pos
   input  wire logic [N_AX*sync_trigger_pkg::POS_W-1:0] i_cmp_up, // Upper cmp
   input  wire logic [N_AX*sync_trigger_pkg::POS_W-1:0] i_cmp_lo, // Lower cmp
   input  wire logic [N_AX-1:0]         i_drv_begin,      // Drive start pulses
   input  wire logic [N_AX-1:0]         i_drv_end,        // Drive end pulses
   input  wire logic [N_AX-1:0]         i_gin3,           // General input three
   output logic [N_AX-1:0]              o_fixed_fwd,      // Fixed drive +
   output logic [N_AX-1:0]              o_fixed_rev,      // Fixed drive -
   output logic [N_AX-1:0]              o_cont_fwd,       // Continuous drive +
   output logic [N_AX-1:0]              o_cont_rev,       // Continuous drive -
   output logic [N_AX-1:0]              o_dec_halt,       // Decelerating halt
   output logic [N_AX-1:0]              o_inst_halt,      // Instant halt
   output logic [N_AX-1:0]              o_lp_load,        // Load logical pos
   output logic [N_AX-1:0]              o_ep_load,        // Load actual pos
   output logic [N_AX-1:0]              o_pcnt_load,      // Load pulse count
   output logic [N_AX-1:0]              o_speed_load,     // Load drive speed
   output logic [N_AX*2*sync_trigger_pkg::DATA_W-1:0] o_load_data, // Load values
   output logic                         o_int_out,        // Interrupt pin level
   output logic                         o_int_oe          // Interrupt pin drive
);
   import sync_trigger_pkg::*;

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [N_AX-1:0]                   axis_sel;
      logic [DATA_W-1:0]                 data_low;
      logic [DATA_W-1:0]                 data_high;
      logic [N_AX-1:0]                   cmp_sel;
      logic [N_AX-1:0][DATA_W-1:0]       trig_cfg;
      logic [N_AX-1:0][DATA_W-1:0]       act_cfg;
      logic [N_AX-1:0]                   sync_flag;
      logic [N_AX-1:0][POS_W-1:0]        sync_buf;
      logic [N_AX-1:0]                   pos_read;
      logic [N_AX-1:0]                   sync_start;
      logic [DATA_W-1:0]                 rdata;
      logic                              int_oe;
   } sync_state_t;

   sync_state_t               st;
   sync_state_t               next_st;
   logic [N_AX-1:0]           fire;
   logic [N_AX-1:0]           go;
   logic [N_AX-1:0][DATA_W-1:0] pulse;

   // Status register index to axis, used by the read path and the clear path
   function automatic logic status_hit(input logic [ADDR_W-1:0] a, input int ax);
      status_hit = (a == ADDR_STATUS_THREE + ADDR_W'(ax));
   endfunction : status_hit

   // ****************************************
   // Per-axis trigger and action units
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < N_AX; g++) begin : g_axis
         sync_trigger_eval u_eval (
            .i_sys_clk   (i_sys_clk),
            .i_rst_n     (i_rst_n),
            .i_trig_cfg  (st.trig_cfg[g]),
            .i_cmp_sel   (st.cmp_sel[g]),
            .i_lp        (i_lp[g*POS_W +: POS_W]),
            .i_ep        (i_ep[g*POS_W +: POS_W]),
            .i_cmp_up    (i_cmp_up[g*POS_W +: POS_W]),
            .i_cmp_lo    (i_cmp_lo[g*POS_W +: POS_W]),
            .i_drv_begin (i_drv_begin[g]),
            .i_drv_end   (i_drv_end[g]),
            .i_gin3      (i_gin3[g]),
            .i_pos_read  (st.pos_read[g]),
            .i_start_cmd (st.sync_start[g]),
            .o_fire      (fire[g])
         );
         sync_action_exec u_exec (
            .i_sys_clk (i_sys_clk),
            .i_rst_n   (i_rst_n),
            .i_go      (go[g]),
            .i_act_cfg (st.act_cfg[g]),
            .i_data    ({st.data_high, st.data_low}),
            .o_pulse   (pulse[g]),
            .o_load    (o_load_data[g*2*DATA_W +: 2*DATA_W])
         );
         // Action pulses leave straight from the action unit's flops
         assign o_fixed_fwd[g]  = pulse[g][ACT_FIXED_FWD];
         assign o_fixed_rev[g]  = pulse[g][ACT_FIXED_REV];
         assign o_cont_fwd[g]   = pulse[g][ACT_CONT_FWD];
         assign o_cont_rev[g]   = pulse[g][ACT_CONT_REV];
         assign o_dec_halt[g]   = pulse[g][ACT_DEC_HALT];
         assign o_inst_halt[g]  = pulse[g][ACT_INST_HALT];
         assign o_lp_load[g]    = pulse[g][ACT_LP_LOAD];
         assign o_ep_load[g]    = pulse[g][ACT_EP_LOAD];
         assign o_pcnt_load[g]  = pulse[g][ACT_PCNT_LOAD];
         assign o_speed_load[g] = pulse[g][ACT_SPEED_LOAD];
      end
   endgenerate

   // ****************************************
   // Cross-axis start
   // ****************************************
   // Bit 13+k of axis b starts axis (b+1+k) mod N, so each axis names the others
   always_comb begin
      go = fire;
      for (int b = 0; b < N_AX; b++) begin
         for (int k = 0; k < N_AX - 1; k++) begin
            if (fire[b] && st.trig_cfg[b][TRIG_OTHER_LSB + k]) begin
               go[(b + 1 + k) % N_AX] = 1'b1;
            end
         end
      end
   end

   // ****************************************
   // Register file, commands, capture, flags
   // ****************************************
   always_comb begin
      logic [7:0] code;
      code               = i_wdata[7:0];
      next_st            = st;
      next_st.pos_read   = '0;
      next_st.sync_start = '0;
      next_st.rdata      = '0;
      // Writes
      if (i_wr) begin
         if (i_addr == ADDR_COMMAND) begin
            next_st.axis_sel = i_wdata[CMD_AXIS_LSB +: N_AX];
            for (int a = 0; a < N_AX; a++) begin
               if (i_wdata[CMD_AXIS_LSB + a]) begin
                  if (code == CMD_SYNC_MODE_SET) begin
                     next_st.trig_cfg[a] = st.data_low;
                     next_st.act_cfg[a]  = st.data_high;
                  end else if (code == CMD_SYNC_START) begin
                     next_st.sync_start[a] = 1'b1;
                  end else if (code == CMD_LP_READ) begin
                     next_st.pos_read[a] = 1'b1;
                  end
               end
            end
         end else if (i_addr == ADDR_DATA_LOW) begin
            next_st.data_low = i_wdata;
         end else if (i_addr == ADDR_DATA_HIGH) begin
            next_st.data_high = i_wdata;
         end else if (i_addr == ADDR_MODE_TWO) begin
            for (int a = 0; a < N_AX; a++) begin
               if (st.axis_sel[a]) begin
                  next_st.cmp_sel[a] = i_wdata[MODE_TWO_CMP_SEL];
               end
            end
         end
      end
      // Reads, data appear in the next cycle only; status read clears the flag
      if (i_rd) begin
         if (i_addr == ADDR_MODE_TWO) begin
            for (int a = N_AX - 1; a >= 0; a--) begin
               if (st.axis_sel[a]) begin
                  next_st.rdata[MODE_TWO_CMP_SEL] = st.cmp_sel[a];
               end
            end
         end else if (i_addr >= ADDR_SYNC_BUF) begin
            for (int a = 0; a < N_AX; a++) begin
               if (i_addr[ADDR_W-2:1] == (ADDR_W-2)'(a)) begin
                  next_st.rdata = i_addr[0] ? st.sync_buf[a][POS_W-1:DATA_W]
                                            : st.sync_buf[a][DATA_W-1:0];
               end
            end
         end else begin
            for (int a = 0; a < N_AX; a++) begin
               if (status_hit(i_addr, a)) begin
                  next_st.rdata[STATUS_THREE_SYNC] = st.sync_flag[a];
                  next_st.sync_flag[a]             = 1'b0;
               end
            end
         end
      end
      // Actions that act inside this block; a new set beats the read clear
      for (int a = 0; a < N_AX; a++) begin
         if (pulse[a][ACT_LP_CAPTURE]) begin
            next_st.sync_buf[a] = i_lp[a*POS_W +: POS_W];
         end
         if (pulse[a][ACT_EP_CAPTURE]) begin
            next_st.sync_buf[a] = i_ep[a*POS_W +: POS_W];
         end
         if (pulse[a][ACT_INTERRUPT]) begin
            next_st.sync_flag[a] = 1'b1;
         end
      end
      next_st.int_oe = |next_st.sync_flag;
   end

   // Reset leaves every trigger and action word cleared
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st          <= '0;
         st.trig_cfg <= {N_AX{TRIG_CFG_RESET}};
         st.act_cfg  <= {N_AX{ACT_CFG_RESET}};
      end else begin
         st <= next_st;
      end
   end

   // Open drain: level is always low, only the enable moves
   assign o_rdata   = st.rdata;
   assign o_int_oe  = st.int_oe;
   assign o_int_out = 1'b0;

   // ****************************************
   // Checks
   // ****************************************
   a_mode_set_loads : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_wr && i_addr == ADDR_COMMAND && i_wdata[7:0] == CMD_SYNC_MODE_SET
       && i_wdata[CMD_AXIS_LSB])
      |=> (st.trig_cfg[0] == $past(st.data_low)) && (st.act_cfg[0] == $past(st.data_high)))
      else $error("sync mode command did not load axis words");
   a_start_cmd_action : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_wr && i_addr == ADDR_COMMAND && i_wdata[7:0] == CMD_SYNC_START
       && i_wdata[CMD_AXIS_LSB] && st.trig_cfg[0][TRIG_START_CMD]
       && st.act_cfg[0][ACT_FIXED_FWD])
      |-> ##3 o_fixed_fwd[0])
      else $error("start command did not drive axis");
   a_cross_start : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (fire[0] && st.trig_cfg[0][TRIG_OTHER_LSB]) |=> (pulse[1] == $past(st.act_cfg[1])))
      else $error("other axis not started");
   a_status_clear : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_rd && i_addr == ADDR_STATUS_THREE && !pulse[0][ACT_INTERRUPT])
      |=> !st.sync_flag[0] && (o_rdata[STATUS_THREE_SYNC] == $past(st.sync_flag[0])))
      else $error("status read did not report and clear flag");
   a_int_pin_follow : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      pulse[2][ACT_INTERRUPT] |=> o_int_oe && st.sync_flag[2])
      else $error("interrupt action did not pull pin");
   a_lp_capture : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (pulse[0][ACT_LP_CAPTURE] && !pulse[0][ACT_EP_CAPTURE])
      |=> st.sync_buf[0] == $past(i_lp[POS_W-1:0]))
      else $error("logical capture missed");
   a_cmp_to_pulse : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(fire[3]) && st.act_cfg[3][ACT_CONT_FWD] && st.trig_cfg[3][TRIG_NUM-1:0] != '0
      |=> o_cont_fwd[3])
      else $error("trigger to action latency wrong");

endmodule : multi_axis_sync_trigger

//--- sync_host_model.sv
`timescale 1ns/1ps
module sync_host_model
   import sync_trigger_pkg::*;
(
   input  wire logic                                i_sys_clk, // System clock
   input  wire logic [sync_trigger_pkg::DATA_W-1:0] i_rdata,   // Read data
   output logic [sync_trigger_pkg::ADDR_W-1:0]      o_addr,    // Register index
   output logic [sync_trigger_pkg::DATA_W-1:0]      o_wdata,   // Write data
   output logic                                     o_wr,      // Write strobe
   output logic                                     o_rd       // Read strobe
);
   // ****************************************
   // Host register cycles
   // ****************************************
   initial {o_addr, o_wdata, o_wr, o_rd} = '0;

   // One-cycle write strobe, released after the taking edge
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge i_sys_clk);
      o_addr  <= a;
      o_wdata <= d;
      o_wr    <= 1'b1;
      @(posedge i_sys_clk);
      o_wr    <= 1'b0;
   endtask : wr

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge i_sys_clk);
      o_addr <= a;
      o_rd   <= 1'b1;
      @(posedge i_sys_clk);
      o_rd   <= 1'b0;
      #1 d = i_rdata;
   endtask : rd

   // Data words go first; the command commits them to the named axis
   task automatic cfg(input int ax, input logic [DATA_W-1:0] trig, input logic [DATA_W-1:0] act,
                      input logic sel);
      wr(ADDR_DATA_LOW, trig);
      wr(ADDR_DATA_HIGH, act);
      wr(ADDR_COMMAND, {4'h0, 4'(1 << ax), CMD_SYNC_MODE_SET});
      wr(ADDR_MODE_TWO, 16'(sel) << MODE_TWO_CMP_SEL);
   endtask : cfg
endmodule : sync_host_model

//--- multi_axis_sync_trigger_bench.sv
`timescale 1ns/1ps
module multi_axis_sync_trigger_bench;
   import sync_trigger_pkg::*;
   // ****************************************
   // Signals, design and host
   // ****************************************
   localparam logic [31:0] FV [4] = '{32'h63, 32'h64, 32'hFFFFFF9C, 32'hFFFFFF9B};
   localparam logic [31:0] TV [4] = '{32'h64, 32'h63, 32'hFFFFFF9B, 32'hFFFFFF9C};
   logic                  i_sys_clk = 1'b0, i_rst_n = 1'b0, i_wr, i_rd, o_int_out, o_int_oe;
   logic [ADDR_W-1:0]     i_addr;
   logic [DATA_W-1:0]     i_wdata, o_rdata;
   logic [4*POS_W-1:0]    i_lp, i_ep, i_cmp_up, i_cmp_lo;
   logic [3:0]            i_drv_begin = '0, i_drv_end = '0, i_gin3 = '0;
   logic [3:0]            o_fixed_fwd, o_fixed_rev, o_cont_fwd, o_cont_rev, o_dec_halt;
   logic [3:0]            o_inst_halt, o_lp_load, o_ep_load, o_pcnt_load, o_speed_load;
   logic [8*DATA_W-1:0]   o_load_data;
   int                    mismatches = 0, samples_checked = 0;

   always #(SYS_CLK_PERIOD_NS / 2) i_sys_clk = ~i_sys_clk;

   multi_axis_sync_trigger u_dut (.i_sys_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
      .o_rdata, .i_lp, .i_ep, .i_cmp_up, .i_cmp_lo, .i_drv_begin, .i_drv_end, .i_gin3,
      .o_fixed_fwd, .o_fixed_rev, .o_cont_fwd, .o_cont_rev, .o_dec_halt, .o_inst_halt,
      .o_lp_load, .o_ep_load, .o_pcnt_load, .o_speed_load, .o_load_data, .o_int_out, .o_int_oe);
   sync_host_model u_host (.i_sys_clk, .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata),
      .o_wr(i_wr), .o_rd(i_rd));

   // ****************************************
   // Checking helpers
   // ****************************************
   function automatic logic [11:0] acts(input int a);
      return {o_speed_load[a], o_pcnt_load[a], o_ep_load[a], o_lp_load[a], 2'b00,
              o_inst_halt[a], o_dec_halt[a], o_cont_rev[a], o_cont_fwd[a], o_fixed_rev[a],
              o_fixed_fwd[a]};
   endfunction : acts

   // Captures have no pin, so their bits never show here
   function automatic logic [11:0] exp_acts(input int act);
      return 12'(1 << act) & 12'hF3F;
   endfunction : exp_acts

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // First pulse in a short window; event pulses are dropped at its first edge
   task automatic watch(input int a, input logic [11:0] exp);
      logic [11:0] v = '0;
      int          n = 0;
      for (int c = 1; c <= 6; c++) begin
         @(posedge i_sys_clk);
         i_drv_begin <= '0;
         i_drv_end   <= '0;
         #1 if (v == 0 && acts(a) != 0) begin
            v = acts(a);
            n = c;
         end
      end
      chk("action", v, exp);
      if (exp != 0) chk("latency", n, TRIG_TO_ACT_CYCLES);
   endtask : watch

   // Source axis ax, trigger bit tb; k < 3 starts another axis, k == 3 acts on ax itself
   task automatic run(input int ax, input int tb, input int act, input int k);
      int          t = (k == 3) ? ax : (ax + 1 + k) % 4;
      logic        sel = 1'($urandom);
      logic [31:0] d = $urandom;
      logic [15:0] trig = 16'(1 << tb), r0, r1;
      if (k != 3) trig[13 + k] = 1'b1;
      @(posedge i_sys_clk);
      i_lp[ax*32+:32] <= FV[tb%4];
      i_ep[ax*32+:32] <= FV[tb%4];
      i_gin3[ax]      <= (tb == 7);
      if (k != 3) u_host.cfg(t, 16'h0000, 16'(1 << act), 1'b0);
      u_host.cfg(ax, trig, (k == 3) ? 16'(1 << act) : 16'h0000, sel);
      u_host.wr(ADDR_DATA_LOW, d[15:0]);
      u_host.wr(ADDR_DATA_HIGH, d[31:16]);
      if (tb < 8) @(posedge i_sys_clk);
      case (tb)
         0, 1, 2, 3: if (sel) i_ep[ax*32+:32] <= TV[tb]; else i_lp[ax*32+:32] <= TV[tb];
         4:          i_drv_begin[ax] <= 1'b1;
         5:          i_drv_end[ax] <= 1'b1;
         6, 7:       i_gin3[ax] <= (tb == 6);
         8:          u_host.wr(ADDR_COMMAND, {4'h0, 4'(1 << ax), CMD_LP_READ});
         default:    u_host.wr(ADDR_COMMAND, {4'h0, 4'(1 << ax), CMD_SYNC_START});
      endcase
      watch(t, exp_acts(act));
      if (act >= ACT_LP_LOAD) chk("load data", o_load_data[t*32+:32], d);
      if (act == ACT_LP_CAPTURE || act == ACT_EP_CAPTURE) begin
         u_host.rd(ADDR_SYNC_BUF + 4'(2 * t), r0);
         u_host.rd(ADDR_SYNC_BUF + 4'(2 * t + 1), r1);
         chk("capture", {r1, r0}, (act == 6) ? i_lp[t*32+:32] : i_ep[t*32+:32]);
      end
   endtask : run

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : wrap_up

   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      logic [15:0] r;
      {i_lp, i_ep} = '0;
      i_cmp_up = {4{32'h00000064}};
      i_cmp_lo = {4{32'hFFFFFF9C}};
      void'($urandom(40));
      repeat (2) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      u_host.rd(ADDR_STATUS_THREE, r);
      chk("status after reset", r, 0);
      u_host.rd(ADDR_DATA_LOW, r);
      chk("write-only read", r, 0);
      for (int a = 0; a < 4; a++) begin
         u_host.wr(ADDR_COMMAND, {8'h0F, CMD_SYNC_START});
         watch(a, '0);
      end
      run(0, 9, ACT_FIXED_FWD, 3);
      run(3, 0, ACT_CONT_FWD, 3);
      run(1, 4, ACT_LP_CAPTURE, 2);
      // Every trigger source once, then random mixes
      for (int i = 0; i < 60; i++)
         run($urandom % 4, (i < 10) ? i : $urandom % 10, $urandom % 12, $urandom % 4);
      u_host.cfg(2, 16'h0200, 16'h8000, 1'b0);
      u_host.wr(ADDR_COMMAND, {8'h04, CMD_SYNC_START});
      repeat (4) @(posedge i_sys_clk);
      #1 chk("int drive", o_int_oe, 1);
      chk("int level", o_int_out, 0);
      u_host.rd(ADDR_STATUS_THREE + 4'h2, r);
      chk("sync flag", r[STATUS_THREE_SYNC], 1);
      @(posedge i_sys_clk);
      #1 chk("int release", o_int_oe, 0);
      wrap_up;
   end

   // Cuts a hang short well beyond the expected run length
   initial begin
      #200000;
      mismatches++;
      wrap_up;
   end
endmodule : multi_axis_sync_trigger_bench
